// file: common/psoc_pkg.sv
package psoc_pkg;
	////////////////////////////////////////////////////////////////////////
	// clock and retest timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int RETEST_ON_NS = 30000;
	// least time, rounded up to whole cycles
	localparam int RETEST_ON_CYCLES = (RETEST_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// duty cycles in tenths of a percent: 0.1 % and 0.8 %
	localparam int DUTY_SLOW_PER_MILLE = 1;
	localparam int DUTY_FAST_PER_MILLE = 8;
	localparam int RETEST_OFF_SLOW_NS = RETEST_ON_NS * 1000 / DUTY_SLOW_PER_MILLE - RETEST_ON_NS;
	localparam int RETEST_OFF_FAST_NS = RETEST_ON_NS * 1000 / DUTY_FAST_PER_MILLE - RETEST_ON_NS;
	localparam int RETEST_OFF_SLOW_CYCLES = RETEST_OFF_SLOW_NS / CLK_PERIOD_NS;
	localparam int RETEST_OFF_FAST_CYCLES = RETEST_OFF_FAST_NS / CLK_PERIOD_NS;
	localparam int RETEST_CNT_W = 19;

	////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_OSC_CFG3 = 8'h71;
	localparam logic [7:0] IDX_OUT_CFG = 8'h72;
	localparam logic [7:0] IDX_HI_UPPER = 8'h73;
	localparam logic [7:0] IDX_HI_LOWER = 8'h74;
	localparam logic [7:0] IDX_LO_UPPER = 8'h75;
	localparam logic [7:0] IDX_LO_LOWER = 8'h76;
	localparam logic [7:0] IDX_PROX_UPPER = 8'h7a;
	localparam logic [7:0] IDX_PROX_LOWER = 8'h7b;
	localparam logic [7:0] IDX_STATUS = 8'h7c;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 9;

	////////////////////////////////////////////////////////////////////////
	// oscillator configuration three fields
	localparam int OC3_UR_EN_BIT = 5;
	localparam int OC3_AMP_LSB = 3;
	localparam int OC3_AMP_MSB = 4;
	localparam int OC3_RESP_LSB = 0;
	localparam int OC3_RESP_MSB = 2;
	localparam logic [7:0] OC3_WMASK = 8'h3f;
	localparam logic [7:0] OSC_CFG3_RST = 8'h1b;

	// output configuration fields
	localparam int OUT_SWCUR_LSB = 6;
	localparam int OUT_SWCUR_MSB = 7;
	localparam int OUT_PNP_BIT = 5;
	localparam int OUT_NC_BIT = 4;
	localparam int OUT_LEDOFF_BIT = 3;
	localparam int OUT_LEDSENSE_BIT = 2;
	localparam int OUT_LEDCUR_BIT = 1;
	localparam int OUT_DUTY_BIT = 0;
	localparam logic [7:0] OUT_CFG_RST = 8'h82;
	localparam logic [7:0] THR_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// conversion tracking and status layout
	localparam logic [2:0] CONV_COUNT_SAT = 3'h4;
	localparam logic [15:0] PROX_FULL_SCALE = 16'hffff;
	localparam int ST_DETECT_BIT = 0;
	localparam int ST_OVERLOAD_BIT = 1;
	localparam int ST_OSC_STOP_BIT = 2;
	localparam int ST_TEMP_OK_BIT = 3;
	localparam int ST_COUNT_LSB = 4;
	localparam int ST_COUNT_MSB = 6;
	localparam int HTRANS_ACTIVE_BIT = 1;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	typedef enum logic [1:0] {
		PSOC_NORMAL = 2'b01,
		PSOC_PROTECT = 2'b10
	} psoc_ovl_e;
endpackage : psoc_pkg

// file: hdl/psoc_retest_timer.sv
`timescale 1ns/10ps
module psoc_retest_timer
	import psoc_pkg::*;
#(
	parameter int ON_CYCLES = RETEST_ON_CYCLES,
	parameter int OFF_SLOW_CYCLES = RETEST_OFF_SLOW_CYCLES,
	parameter int OFF_FAST_CYCLES = RETEST_OFF_FAST_CYCLES,
	parameter int CNT_W = RETEST_CNT_W
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic enable,
	input wire logic fast_duty,
	output logic retest_on,
	output logic retest_end
);
	logic [CNT_W-1:0] cnt_reg;
	logic on_reg;
	logic [CNT_W-1:0] off_last;
	logic [CNT_W-1:0] on_last;

	////////////////////////////////////////////////////////////////////////
	// the off period is picked live so a duty change takes effect in the off period under way
	assign off_last = fast_duty ? CNT_W'(OFF_FAST_CYCLES - 1) : CNT_W'(OFF_SLOW_CYCLES - 1);
	assign on_last = CNT_W'(ON_CYCLES - 1);

	// off first, then one on window; dropping enable restarts the period
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= '0;
			on_reg <= 1'b0;
		end else if (!enable) begin
			cnt_reg <= '0;
			on_reg <= 1'b0;
		end else if (on_reg) begin
			if (cnt_reg == on_last) begin
				cnt_reg <= '0;
				on_reg <= 1'b0;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end else if (cnt_reg >= off_last) begin
			cnt_reg <= '0;
			on_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	assign retest_on = on_reg;
	assign retest_end = on_reg && (cnt_reg == on_last); // last on cycle
endmodule : psoc_retest_timer

// file: hdl/psoc_top.sv
// Summary of operation
// - under range in first four conversions stops oscillation and turns the switch on.
// - later under range with enable set forces full scale and switch on.
// - later under range with enable clear holds the switch state.
// - before a temperature conversion the switch stays unchanged, no under-range action.
// - lower response setting means a faster, noisier filter; higher is slower, quieter.
// - output config bits 7:6 choose the switch drive current.
// - output config bit 5 chooses NPN or PNP topology.
// - normally open: off when far, conducting when near.
// - normally closed: conducting when far, off when near.
// - bit 3 high keeps the LED off, low lets it follow its mode.
// - LED normally off: dark when far, lit when near.
// - LED normally on: lit when far, dark when near.
// - bit 1 chooses Indicator_current_sel, 5 mA by default.
// - overload retests with 30 us on pulses at 0.1 or 0.8 percent duty.
// - high threshold is upper and lower byte, both reset to zero.
// - low threshold is upper and lower byte, both reset to zero.
// - reading proximity upper captures both bytes; lower stays frozen until next.
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
module psoc_top
	import psoc_pkg::*;
#(
	parameter int ADDR_W = 32,
	parameter int OFF_SLOW_CYCLES = RETEST_OFF_SLOW_CYCLES,
	parameter int OFF_FAST_CYCLES = RETEST_OFF_FAST_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic [1:0] hresp,
	input wire logic conv_done,
	input wire logic [15:0] conv_result,
	input wire logic under_range,
	input wire logic temp_conv_done,
	input wire logic overload_sense,
	output logic oscillation_stop,
	output logic [1:0] oscillation_amplitude_sel,
	output logic switch_drive_out,
	output logic [1:0] switch_drive_current_sel,
	output logic switch_topology_pnp,
	output logic indicator_out,
	output logic indicator_current_sel
);
	logic [7:0] osc_cfg3_reg, osc_cfg3_next;
	logic [7:0] out_cfg_reg, out_cfg_next;
	logic [7:0] hi_upper_reg, hi_upper_next, hi_lower_reg, hi_lower_next;
	logic [7:0] lo_upper_reg, lo_upper_next, lo_lower_reg, lo_lower_next;
	logic [7:0] prox_upper_reg, prox_lower_reg;
	logic [7:0] rdata_reg, rd_byte;
	logic wr_pend_reg;
	logic [7:0] wr_idx_reg;
	logic [7:0] acc_idx;
	logic acc_valid, rd_acc;
	logic [15:0] filt_reg, filt_next, thr_high, thr_low;
	logic [2:0] conv_count_reg;
	logic temp_ok_reg, detect_reg, osc_stop_reg;
	logic ovl_sync1_reg, ovl_sync2_reg;
	logic sw_out_reg, led_out_reg;
	logic early_phase, ur_act;
	logic retest_on, retest_end;
	psoc_ovl_e ovl_state_reg;

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic wr_hit(input logic pend, input logic [7:0] widx, input logic [7:0] target);
		wr_hit = pend && (widx == target);
	endfunction : wr_hit

	// step size of the smoothing filter; code 0 is reserved and treated as 1
	function automatic logic [2:0] filt_shift(input logic [2:0] sel);
		filt_shift = (sel == 3'h0) ? 3'h0 : 3'(sel - 3'h1);
	endfunction : filt_shift

	////////////////////////////////////////////////////////////////////////
	// ahb-lite address phase; zero wait states, so hreadyout is always high
	assign acc_valid = hsel && hready && htrans[HTRANS_ACTIVE_BIT];
	assign acc_idx = haddr[IDX_MSB:IDX_LSB];
	assign rd_acc = acc_valid && !hwrite;
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign hrdata = {24'h000000, rdata_reg};

	// write is captured in the address phase, data taken in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= 8'h00;
		end else begin
			wr_pend_reg <= acc_valid && hwrite;
			wr_idx_reg <= acc_idx;
		end
	end

	// next register values; reads use them so a read right after a write sees it
	always_comb begin
		osc_cfg3_next = osc_cfg3_reg;
		out_cfg_next = out_cfg_reg;
		hi_upper_next = hi_upper_reg;
		hi_lower_next = hi_lower_reg;
		lo_upper_next = lo_upper_reg;
		lo_lower_next = lo_lower_reg;
		if (wr_hit(wr_pend_reg, wr_idx_reg, IDX_OSC_CFG3)) begin
			osc_cfg3_next = hwdata[7:0] & OC3_WMASK; // reserved bits stay zero
		end
		if (wr_hit(wr_pend_reg, wr_idx_reg, IDX_OUT_CFG)) begin
			out_cfg_next = hwdata[7:0];
		end
		if (wr_hit(wr_pend_reg, wr_idx_reg, IDX_HI_UPPER)) begin
			hi_upper_next = hwdata[7:0];
		end
		if (wr_hit(wr_pend_reg, wr_idx_reg, IDX_HI_LOWER)) begin
			hi_lower_next = hwdata[7:0];
		end
		if (wr_hit(wr_pend_reg, wr_idx_reg, IDX_LO_UPPER)) begin
			lo_upper_next = hwdata[7:0];
		end
		if (wr_hit(wr_pend_reg, wr_idx_reg, IDX_LO_LOWER)) begin
			lo_lower_next = hwdata[7:0];
		end
	end

	// configuration and threshold storage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_cfg3_reg <= OSC_CFG3_RST;
			out_cfg_reg <= OUT_CFG_RST;
			hi_upper_reg <= THR_RST;
			hi_lower_reg <= THR_RST;
			lo_upper_reg <= THR_RST;
			lo_lower_reg <= THR_RST;
		end else begin
			osc_cfg3_reg <= osc_cfg3_next;
			out_cfg_reg <= out_cfg_next;
			hi_upper_reg <= hi_upper_next;
			hi_lower_reg <= hi_lower_next;
			lo_upper_reg <= lo_upper_next;
			lo_lower_reg <= lo_lower_next;
		end
	end

	assign thr_high = {hi_upper_reg, hi_lower_reg};
	assign thr_low = {lo_upper_reg, lo_lower_reg};

	// read multiplexer; unmapped indices read as zero
	always_comb begin
		case (acc_idx)
			IDX_OSC_CFG3: rd_byte = osc_cfg3_next;
			IDX_OUT_CFG: rd_byte = out_cfg_next;
			IDX_HI_UPPER: rd_byte = hi_upper_next;
			IDX_HI_LOWER: rd_byte = hi_lower_next;
			IDX_LO_UPPER: rd_byte = lo_upper_next;
			IDX_LO_LOWER: rd_byte = lo_lower_next;
			IDX_PROX_UPPER: rd_byte = filt_reg[15:8];
			IDX_PROX_LOWER: rd_byte = prox_lower_reg;
			IDX_STATUS: begin
				rd_byte = 8'h00;
				rd_byte[ST_DETECT_BIT] = detect_reg;
				rd_byte[ST_OVERLOAD_BIT] = (ovl_state_reg == PSOC_PROTECT);
				rd_byte[ST_OSC_STOP_BIT] = osc_stop_reg;
				rd_byte[ST_TEMP_OK_BIT] = temp_ok_reg;
				rd_byte[ST_COUNT_MSB:ST_COUNT_LSB] = conv_count_reg;
			end
			default: rd_byte = 8'h00;
		endcase
	end

	// read data is registered at the address-phase edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_reg <= 8'h00;
		end else if (rd_acc) begin
			rdata_reg <= rd_byte;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prox_upper_reg <= 8'h00;
			prox_lower_reg <= 8'h00;
		end else if (rd_acc && (acc_idx == IDX_PROX_UPPER)) begin
			prox_upper_reg <= filt_reg[15:8];
			prox_lower_reg <= filt_reg[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// conversion bookkeeping

	// temperature conversion seen since reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			temp_ok_reg <= 1'b0;
		end else if (temp_conv_done) begin
			temp_ok_reg <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conv_count_reg <= 3'h0;
		end else if (conv_done && (conv_count_reg < CONV_COUNT_SAT)) begin
			conv_count_reg <= conv_count_reg + 3'h1;
		end
	end

	assign ur_act = conv_done && under_range && temp_ok_reg;
	assign early_phase = conv_count_reg < CONV_COUNT_SAT;

	// shift-based smoothing, small setting settles fast
	always_comb begin
		logic signed [16:0] diff;
		diff = $signed({1'b0, conv_result}) - $signed({1'b0, filt_reg});
		filt_next = filt_reg + 16'(diff >>> filt_shift(osc_cfg3_reg[OC3_RESP_MSB:OC3_RESP_LSB]));
	end

	// filtered proximity value; frozen while the tank is under range, except forced to full scale when enabled after the first four conversions
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			filt_reg <= 16'h0000;
		end else if (ur_act && !early_phase && osc_cfg3_reg[OC3_UR_EN_BIT]) begin
			filt_reg <= PROX_FULL_SCALE;
		end else if (conv_done && !under_range) begin
			filt_reg <= filt_next;
		end
	end

	// detection state; high threshold checked first if thresholds overlap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			detect_reg <= 1'b0;
		end else if (conv_done && temp_ok_reg) begin
			if (under_range) begin
				if (early_phase) begin
					detect_reg <= 1'b1;
				end else if (osc_cfg3_reg[OC3_UR_EN_BIT]) begin
					detect_reg <= 1'b1;
				end
			end else if (filt_next >= thr_high) begin
				detect_reg <= 1'b1;
			end else if (filt_next <= thr_low) begin
				detect_reg <= 1'b0;
			end
		end
	end

	// oscillation stop; set wins over release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_stop_reg <= 1'b0;
		end else if (ur_act && early_phase) begin
			osc_stop_reg <= 1'b1;
		end else if (!under_range) begin
			osc_stop_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// overload protection; the sense comes straight from a pin
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovl_sync1_reg <= 1'b0;
			ovl_sync2_reg <= 1'b0;
		end else begin
			ovl_sync1_reg <= overload_sense;
			ovl_sync2_reg <= ovl_sync1_reg;
		end
	end

	// overload is only judged while the switch conducts, else the sense is meaningless
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovl_state_reg <= PSOC_NORMAL;
		end else begin
			case (ovl_state_reg)
				PSOC_NORMAL: begin
					if (ovl_sync2_reg && sw_out_reg) begin
						ovl_state_reg <= PSOC_PROTECT;
					end
				end
				PSOC_PROTECT: begin
					if (retest_end && !ovl_sync2_reg) begin
						ovl_state_reg <= PSOC_NORMAL;
					end
				end
				default: ovl_state_reg <= PSOC_NORMAL;
			endcase
		end
	end

	psoc_retest_timer #(
		.ON_CYCLES(RETEST_ON_CYCLES),
		.OFF_SLOW_CYCLES(OFF_SLOW_CYCLES),
		.OFF_FAST_CYCLES(OFF_FAST_CYCLES),
		.CNT_W(RETEST_CNT_W)
	) u_retest (
		.hclk(hclk),
		.hresetn(hresetn),
		.enable(ovl_state_reg == PSOC_PROTECT),
		.fast_duty(out_cfg_reg[OUT_DUTY_BIT]),
		.retest_on(retest_on),
		.retest_end(retest_end)
	);

	////////////////////////////////////////////////////////////////////////
	// output drive; registered so the pins never glitch on config writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_out_reg <= 1'b0;
		end else if (ovl_state_reg == PSOC_PROTECT) begin
			sw_out_reg <= retest_on;
		end else begin
			sw_out_reg <= detect_reg ^ out_cfg_reg[OUT_NC_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			led_out_reg <= 1'b0;
		end else begin
			led_out_reg <= !out_cfg_reg[OUT_LEDOFF_BIT] && (detect_reg ^ out_cfg_reg[OUT_LEDSENSE_BIT]);
		end
	end

	assign switch_drive_out = sw_out_reg;
	assign indicator_out = led_out_reg;
	assign oscillation_stop = osc_stop_reg;
	assign oscillation_amplitude_sel = osc_cfg3_reg[OC3_AMP_MSB:OC3_AMP_LSB];
	assign switch_drive_current_sel = out_cfg_reg[OUT_SWCUR_MSB:OUT_SWCUR_LSB];
	assign switch_topology_pnp = out_cfg_reg[OUT_PNP_BIT];
	assign indicator_current_sel = out_cfg_reg[OUT_LEDCUR_BIT];

	////////////////////////////////////////////////////////////////////////
	// checks
	logic [RETEST_CNT_W-1:0] on_len_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			on_len_reg <= '0;
		end else if (switch_drive_out && ovl_state_reg == PSOC_PROTECT) begin
			on_len_reg <= on_len_reg + 1'b1;
		end else begin
			on_len_reg <= '0;
		end
	end

	count_saturate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		conv_done && conv_count_reg == 3'h3 |=> conv_count_reg == CONV_COUNT_SAT ##1 conv_count_reg <= CONV_COUNT_SAT)
		else $error("conversion count left its range");

	temp_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!temp_ok_reg |=> $stable(detect_reg) && !osc_stop_reg)
		else $error("switch changed before temperature conversion");

	early_under_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ur_act && early_phase |=> osc_stop_reg && detect_reg)
		else $error("early under range did not stop and switch");

	full_scale_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ur_act && !early_phase && osc_cfg3_reg[OC3_UR_EN_BIT] |=> filt_reg == PROX_FULL_SCALE && detect_reg)
		else $error("enabled under range did not force full scale");

	under_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ur_act && !early_phase && !osc_cfg3_reg[OC3_UR_EN_BIT] |=> $stable(detect_reg) && $stable(filt_reg))
		else $error("disabled under range changed the switch");

	hysteresis_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		conv_done && temp_ok_reg && !under_range && filt_next < thr_high && filt_next > thr_low
		|=> $stable(detect_reg))
		else $error("detection moved between thresholds");

	switch_sense_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ovl_state_reg == PSOC_NORMAL && $stable(ovl_state_reg) ##1 ovl_state_reg == PSOC_NORMAL
		|-> switch_drive_out == ($past(detect_reg) ^ $past(out_cfg_reg[OUT_NC_BIT])))
		else $error("switch sense wrong");

	led_sense_a: assert property (@(posedge hclk) disable iff (!hresetn)
		##1 indicator_out == (!$past(out_cfg_reg[OUT_LEDOFF_BIT]) && ($past(detect_reg) ^ $past(out_cfg_reg[OUT_LEDSENSE_BIT]))))
		else $error("indicator sense wrong");

	retest_width_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(switch_drive_out) && ovl_state_reg == PSOC_PROTECT && $past(ovl_state_reg) == PSOC_PROTECT
		&& $past(ovl_state_reg, 2) == PSOC_PROTECT
		|-> on_len_reg == RETEST_CNT_W'(RETEST_ON_CYCLES))
		else $error("retest on window has wrong length");

	prox_freeze_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!(rd_acc && acc_idx == IDX_PROX_UPPER) |=> $stable(prox_lower_reg))
		else $error("proximity lower byte changed without upper read");
endmodule : psoc_top

// file: hdl/_unused_guard.sv
`timescale 1ns/10ps

// file: tb/psoc_far_side.sv
`timescale 1ns/10ps
module psoc_far_side (
	input wire logic hclk,
	output logic conv_done,
	output logic [15:0] conv_result,
	output logic under_range,
	output logic temp_conv_done,
	output logic overload_sense
);
	// quiet converter at time zero
	initial begin
		conv_done = 1'b0;
		conv_result = 16'h0000;
		under_range = 1'b0;
		temp_conv_done = 1'b0;
		overload_sense = 1'b0;
	end
	// result bus flips outside the strobe so a stale value cannot pass
	task automatic convert(input logic [15:0] v, input logic ur);
		conv_done <= 1'b1;
		conv_result <= v;
		under_range <= ur;
		@(posedge hclk);
		conv_done <= 1'b0;
		conv_result <= ~v;
		@(posedge hclk);
	endtask : convert
	task automatic temp();
		temp_conv_done <= 1'b1;
		@(posedge hclk);
		temp_conv_done <= 1'b0;
		@(posedge hclk);
	endtask : temp
endmodule : psoc_far_side

// file: tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
	import psoc_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0, hresp, amp, swcur;
	logic [2:0] hsize = 3'h2;
	logic hready, stp, sw, pnp, led, ledcur, cd, ur, td, ov;
	logic [15:0] cres, hi, lo, filt = 16'h0;
	// reference model state
	logic det = 1'b0, stop = 1'b0;
	logic [7:0] cfg = OUT_CFG_RST, cfg3 = OSC_CFG3_RST, rd;
	int cnt = 0, n, n_errors = 0, n_tests = 0;
	bit tok = 0;
	always #50 hclk = ~hclk;
	psoc_top #(.OFF_SLOW_CYCLES(20), .OFF_FAST_CYCLES(10)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .conv_done(cd), .conv_result(cres),
		.under_range(ur), .temp_conv_done(td), .overload_sense(ov), .oscillation_stop(stp),
		.oscillation_amplitude_sel(amp), .switch_drive_out(sw), .switch_drive_current_sel(swcur),
		.switch_topology_pnp(pnp), .indicator_out(led), .indicator_current_sel(ledcur));
	psoc_far_side far (.hclk(hclk), .conv_done(cd), .conv_result(cres), .under_range(ur),
		.temp_conv_done(td), .overload_sense(ov));
	////////////////////////////////////////////////////////////////////////
	// one single word transfer; waits on hready, never on a fixed count
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata[7:0];
	endtask : bus
	task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		`CHK("rdata", e, rd)
		`CHK("resp", HRESP_OKAY, hresp)
		`CHK("upper", 24'h000000, hrdata[31:8])
	endtask : rdc
	// pins lag the cause by up to two edges; sampled at the falling edge
	task automatic pins();
		repeat (2) @(posedge hclk);
		@(negedge hclk);
		`CHK("switch", det ^ cfg[4], sw)
		`CHK("led", ~cfg[3] & (det ^ cfg[2]), led)
		`CHK("stop", stop, stp)
		`CHK("static", {cfg[7:5], cfg[1], cfg3[4:3]}, {swcur, pnp, ledcur, amp})
		@(posedge hclk);
	endtask : pins
	// one conversion through the partner, then the model and a compare
	task automatic cv(input logic [15:0] v, input logic u);
		int d;
		far.convert(v, u);
		// smoothing step: response code 0 behaves as 1, code 1 passes the raw value
		d = (int'(v) - int'(filt)) >>> ((cfg3[2:0] > 3'h1) ? cfg3[2:0] - 3'h1 : 3'h0);
		if (!u) filt = filt + 16'(d);
		if (!u) stop = 1'b0;
		if (tok && u && cnt < 4) begin
			det = 1'b1;
			stop = 1'b1;
		end else if (tok && u && cfg3[OC3_UR_EN_BIT]) begin
			det = 1'b1;
			filt = PROX_FULL_SCALE;
		end else if (tok && !u && filt >= hi) det = 1'b1;
		else if (tok && !u && filt <= lo) det = 1'b0;
		if (cnt < 4) cnt++;
		pins();
	endtask : cv
	task automatic run_len(input logic lv, output int k);
		k = 0;
		while (sw === lv && k < 5000) begin
			@(negedge hclk);
			k++;
		end
	endtask : run_len
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////////
	// watchdog: the whole run needs a few thousand cycles
	initial begin
		repeat (20000) @(posedge hclk);
		n_errors++;
		print_verdict();
	end
	initial begin
		void'($urandom(35));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc(IDX_OSC_CFG3, OSC_CFG3_RST);
		rdc(IDX_OUT_CFG, OUT_CFG_RST);
		for (int i = 0; i < 4; i++) rdc(IDX_HI_UPPER + i[7:0], THR_RST);
		pins();
		$display("reset values done");
		// software picks a valid amplitude and the thresholds
		cfg3 = 8'h09;
		bus(1'b1, IDX_OSC_CFG3, cfg3);
		hi = 16'h8000 + 16'($urandom_range(16'h3fff));
		lo = hi - 16'h3000;
		for (int i = 0; i < 4; i++) bus(1'b1, IDX_HI_UPPER + i[7:0], 8'({hi, lo} >> (24 - 8 * i)));
		rdc(IDX_LO_UPPER, lo[15:8]);
		cv(hi, 1'b1);
		cv(hi, 1'b0);
		far.temp();
		tok = 1;
		cv(lo, 1'b1);
		cv(lo, 1'b0);
		repeat (16) cv(16'($urandom), 1'b0);
		cv(hi, 1'b0);
		cv(lo + 16'h1, 1'b0);
		cv(lo, 1'b0);
		cv(lo, 1'b1);
		$display("detection done");
		cfg3 = 8'h29;
		bus(1'b1, IDX_OSC_CFG3, cfg3);
		cv(lo, 1'b1);
		rdc(IDX_PROX_UPPER, filt[15:8]);
		cv(hi, 1'b0);
		rdc(IDX_PROX_UPPER, hi[15:8]);
		cv(lo, 1'b0);
		rdc(IDX_PROX_LOWER, hi[7:0]);
		$display("under range and capture done");
		for (int k = 0; k < 8; k++) begin
			cfg = {3'($urandom), k[2:0], 2'($urandom)};
			bus(1'b1, IDX_OUT_CFG, cfg);
			pins();
		end
		rdc(IDX_OUT_CFG, cfg);
		$display("output modes done");
		for (int d = 0; d < 2; d++) begin
			cfg = {7'h40, d[0]};
			bus(1'b1, IDX_OUT_CFG, cfg);
			cv(hi, 1'b0);
			far.overload_sense <= 1'b1;
			run_len(1'b1, n);
			run_len(1'b0, n);
			run_len(1'b1, n);
			`CHK("on_len", RETEST_ON_CYCLES, n)
			run_len(1'b0, n);
			`CHK("off_len", (d == 1) ? 10 : 20, n)
			far.overload_sense <= 1'b0;
			repeat (400) @(posedge hclk);
			pins();
		end
		$display("overload done");
		// half-step smoothing on a falling value
		cfg3 = 8'h0a;
		bus(1'b1, IDX_OSC_CFG3, cfg3);
		cv(lo, 1'b0);
		rdc(IDX_PROX_UPPER, filt[15:8]);
		rdc(IDX_PROX_LOWER, filt[7:0]);
		$display("filter done");
		bus(1'b1, IDX_OSC_CFG3, 8'hff);
		rdc(IDX_OSC_CFG3, 8'h3f);
		rdc(8'h10, 8'h00);
		rdc(IDX_STATUS, {1'b0, 3'(cnt), tok, stop, 1'b0, det});
		print_verdict();
	end
endmodule : tb_top
